// *** logic/cam_pkg.sv ***
// constants and carrier types for the counter array mode and pwm configuration block
`default_nettype none
package cam_pkg;
    // register byte addresses on the special function register bus
    localparam logic [7:0] CAM_MODE_ADDR = 8'hD9;
    localparam logic [7:0] CAM_PWM_ADDR = 8'hF4;
    // compare low/high byte addresses, channel n at base + n
    localparam logic [7:0] CAM_CMP_LOW_BASE = 8'hE9;
    localparam logic [7:0] CAM_CMP_HIGH_BASE = 8'hFB;
    // mode register field positions
    localparam int CAM_IDLE_BIT = 7;
    localparam int CAM_WATCHDOG_ENABLE_BIT_BIT = 6;
    localparam int CAM_WATCHDOG_LOCK_BIT_BIT = 5;
    localparam int CAM_TB_LSB = 1;
    localparam int CAM_ECF_BIT = 0;
    // pwm configuration field positions
    localparam int CAM_RELOAD_BANK_SELECT_BIT = 7;
    localparam int CAM_CYCLE_OVERFLOW_IRQ_ENABLE_BIT = 6;
    localparam int CAM_CYCLE_OVERFLOW_FLAG_BIT = 5;
    localparam int CAM_CLSEL_LSB = 0;
    // timebase codes
    localparam logic [2:0] CAM_TB_DIV12 = 3'h0;
    localparam logic [2:0] CAM_TB_DIV4 = 3'h1;
    localparam logic [2:0] CAM_TB_TIMER0 = 3'h2;
    localparam logic [2:0] CAM_TB_ECI = 3'h3;
    localparam logic [2:0] CAM_TB_SYSCLK = 3'h4;
    localparam logic [2:0] CAM_TB_EXTDIV8 = 3'h5;
    // divider counts in system clocks / external edges
    localparam logic [3:0] CAM_DIV12_COUNT = 4'hC;
    localparam logic [3:0] CAM_DIV4_COUNT = 4'h4;
    localparam logic [3:0] CAM_EXT_DIV_COUNT = 4'h8;
    // reset values
    localparam logic CAM_WATCHDOG_ENABLE_BIT_RESET = 1'b1;
    localparam logic [2:0] CAM_TB_RESET = CAM_TB_DIV12;
    localparam logic [15:0] CAM_COUNTER_RESET = 16'h0000;
    localparam logic [7:0] CAM_RDATA_RESET = 8'h00;

    // one register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } cam_sfr_req_type;

    // mode register contents
    typedef struct packed {
        logic idle_suspend_select;
        logic watchdog_enable_bit;
        logic watchdog_lock_bit;
        logic [2:0] timebase_select;
        logic counter_overflow_irq_enable;
    } cam_mode_type;

    // pwm configuration contents
    typedef struct packed {
        logic reload_bank_select;
        logic cycle_overflow_irq_enable;
        logic cycle_overflow_flag;
        logic [1:0] cycle_length_select;
    } cam_pwm_type;
endpackage : cam_pkg
`default_nettype wire

// *** logic/cam_mode_pwm.sv ***
// counter array mode, timebase, main counter and pwm cycle configuration
// How it works
// (RULE1) idle suspend bit halts array during idle
// (RULE2) watchdog enable hands module 4 to watchdog
// (RULE3) lock blocks watchdog disable until reset
// (RULE4) codes 000/001/010: div12, div4, timer0
// (RULE5) code 011 counts synced external input falls
// (RULE6) 100 sysclk, 101 external/8, 11x reserved
// (RULE7) counter overflow flag plus enable requests irq
// (RULE8) watchdog on freezes other mode bits; code freezes them only while the enable bit is set, not on lock alone
// (RULE9) bank select steers compare addresses to reload
// (RULE10) reload values matter only for 9-11 bits
// (RULE11) cycle overflow flag plus enable requests irq
// (RULE12) cycle flag set from selected counter bit
// (RULE13) cycle flag sticky until software clears
// (RULE14) cycle length codes give 8,9,10,11 bits
// (RULE15) 16-bit channels ignore cycle length
// (RULE16) pwm bits 4:2 read zero, ignore writes
// (RULE17) counter wrap from max sets overflow flag
// (RULE18) enable or lock bit turns watchdog on
// (RULE19) reset leaves watchdog on, timebase div12
// (RULE20) counter steps once per enabled tick
`timescale 1ns/10ps
`default_nettype none
module cam_mode_pwm #(
    parameter int NCH = 5
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register bus
    input wire cam_pkg::cam_sfr_req_type sfr_req,
    output logic [7:0] sfr_rdata,
    output logic sfr_rdata_hit,
    // system status from same clock domain
    input wire logic cpu_idle,
    input wire logic run_enable,
    input wire logic timer0_overflow,
    input wire logic counter_flag_clear,
    input wire logic [NCH-1:0] pwm16_mode,
    // pins from outside the clock domain
    input wire logic external_count_input,
    input wire logic external_clock,
    // results
    output logic [15:0] main_counter,
    output logic timebase_tick,
    output logic counter_overflow_flag,
    output logic cycle_overflow_flag,
    output logic irq,
    output logic watchdog_active,
    output logic [NCH-1:0] channel_cycle_wrap,
    output logic [16*NCH-1:0] reload_value
);
    import cam_pkg::*;

    // reset release synchroniser
    logic [1:0] rst_pipe;
    logic rst_sync_n;
    // pin synchronisers, first stage read only by second
    logic [1:0] eci_sync;
    logic [1:0] ext_sync;
    logic eci_last;
    logic ext_last;
    // register state
    cam_mode_type mode;
    cam_pwm_type pwm;
    logic [15:0] reload_mem [NCH];
    // timebase dividers
    logic [3:0] div12_cnt;
    logic [3:0] div4_cnt;
    logic [3:0] ext_cnt;
    logic div12_hit;
    logic div4_hit;
    logic ext_hit;
    logic eci_fall;
    logic next_tick;
    logic advance;
    logic wrap16;
    logic cycle_wrap;
    logic [3:0] cycle_bits;
    logic mode_wr;
    logic pwm_wr;

    // hold reset until two clean clock edges after release
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_pipe[1];

    // bring both pins into the clock domain
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            eci_sync <= 2'h3;
            ext_sync <= 2'h0;
            eci_last <= 1'b1;
            ext_last <= 1'b0;
        end else begin
            eci_sync <= {eci_sync[0], external_count_input};
            ext_sync <= {ext_sync[0], external_clock};
            eci_last <= eci_sync[1];
            ext_last <= ext_sync[1];
        end
    end
    // falling edge only seen reliably up to a quarter of sysclk
    assign eci_fall = eci_last & ~eci_sync[1]; // RULE5

    // address decode
    assign mode_wr = sfr_req.wr && (sfr_req.addr == CAM_MODE_ADDR);
    assign pwm_wr = sfr_req.wr && (sfr_req.addr == CAM_PWM_ADDR);

    // mode register with watchdog freeze and lock
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mode.idle_suspend_select <= 1'b0;
            mode.watchdog_enable_bit <= CAM_WATCHDOG_ENABLE_BIT_RESET; // RULE19
            mode.watchdog_lock_bit <= 1'b0; // RULE3
            mode.timebase_select <= CAM_TB_RESET; // RULE19
            mode.counter_overflow_irq_enable <= 1'b0;
        end else if (mode_wr) begin
            if (mode.watchdog_enable_bit) begin
                // only the enable may move; a lock pins it high
                mode.watchdog_enable_bit <= sfr_req.wdata[CAM_WATCHDOG_ENABLE_BIT_BIT] | mode.watchdog_lock_bit; // RULE8 RULE3
            end else begin
                mode.idle_suspend_select <= sfr_req.wdata[CAM_IDLE_BIT];
                mode.watchdog_enable_bit <= sfr_req.wdata[CAM_WATCHDOG_ENABLE_BIT_BIT];
                // a set lock stays set until reset
                mode.watchdog_lock_bit <= sfr_req.wdata[CAM_WATCHDOG_LOCK_BIT_BIT] | mode.watchdog_lock_bit; // RULE3
                mode.timebase_select <= sfr_req.wdata[CAM_TB_LSB +: 3];
                mode.counter_overflow_irq_enable <= sfr_req.wdata[CAM_ECF_BIT];
            end
        end
    end

    // watchdog state handed to module 4
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            watchdog_active <= CAM_WATCHDOG_ENABLE_BIT_RESET; // RULE19
        end else begin
            // either bit keeps module 4 in watchdog duty
            watchdog_active <= mode.watchdog_enable_bit | mode.watchdog_lock_bit; // RULE2 RULE18
        end
    end

    // pwm configuration, unused bits are not stored
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pwm.reload_bank_select <= 1'b0;
            pwm.cycle_overflow_irq_enable <= 1'b0;
            pwm.cycle_length_select <= 2'h0;
        end else if (pwm_wr) begin
            pwm.reload_bank_select <= sfr_req.wdata[CAM_RELOAD_BANK_SELECT_BIT];
            pwm.cycle_overflow_irq_enable <= sfr_req.wdata[CAM_CYCLE_OVERFLOW_IRQ_ENABLE_BIT];
            pwm.cycle_length_select <= sfr_req.wdata[CAM_CLSEL_LSB +: 2];
        end
    end

    // cycle overflow flag, hardware set wins over a software clear
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pwm.cycle_overflow_flag <= 1'b0;
        end else if (cycle_wrap) begin
            pwm.cycle_overflow_flag <= 1'b1; // RULE12 RULE13
        end else if (pwm_wr) begin
            // software may set or clear it
            pwm.cycle_overflow_flag <= sfr_req.wdata[CAM_CYCLE_OVERFLOW_FLAG_BIT]; // RULE13
        end
    end

    // free running dividers for the sysclk timebases
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            div12_cnt <= 4'h0;
            div4_cnt <= 4'h0;
        end else begin
            div12_cnt <= div12_hit ? 4'h0 : div12_cnt + 4'h1;
            div4_cnt <= div4_hit ? 4'h0 : div4_cnt + 4'h1;
        end
    end
    assign div12_hit = (div12_cnt == CAM_DIV12_COUNT - 4'h1);
    assign div4_hit = (div4_cnt == CAM_DIV4_COUNT - 4'h1);

    // external clock divided by eight on synced rising edges
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ext_cnt <= 4'h0;
        end else if (ext_sync[1] & ~ext_last) begin
            ext_cnt <= ext_hit ? 4'h0 : ext_cnt + 4'h1;
        end
    end
    assign ext_hit = (ext_cnt == CAM_EXT_DIV_COUNT - 4'h1);

    // pick the timebase event
    always_comb begin
        next_tick = 1'b0;
        unique case (mode.timebase_select)
            CAM_TB_DIV12: next_tick = div12_hit; // RULE4
            CAM_TB_DIV4: next_tick = div4_hit; // RULE4
            CAM_TB_TIMER0: next_tick = timer0_overflow; // RULE4
            CAM_TB_ECI: next_tick = eci_fall; // RULE5
            CAM_TB_SYSCLK: next_tick = 1'b1; // RULE6
            CAM_TB_EXTDIV8: next_tick = ext_hit & ext_sync[1] & ~ext_last; // RULE6
            // reserved codes never tick
            default: next_tick = 1'b0; // RULE6
        endcase
    end

    // a tick counts only when running and not idle-suspended
    assign advance = next_tick & run_enable & ~(cpu_idle & mode.idle_suspend_select); // RULE1 RULE20

    // registered copy of the effective tick
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            timebase_tick <= 1'b0;
        end else begin
            timebase_tick <= advance;
        end
    end

    // main counter steps once per effective tick
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            main_counter <= CAM_COUNTER_RESET;
        end else if (advance) begin
            main_counter <= main_counter + 16'h0001; // RULE20
        end
    end

    // overflow points: full width and selected cycle length
    assign wrap16 = advance && (main_counter == 16'hFFFF); // RULE17
    // code 11 gives the eleven-bit cycle
    assign cycle_bits = 4'h8 + {2'h0, pwm.cycle_length_select}; // RULE14
    // carry out of the chosen bit when all lower bits are ones
    assign cycle_wrap = advance && (&(main_counter | ~((16'h0001 << cycle_bits) - 16'h0001))); // RULE12

    // counter overflow flag, set wins over the clear strobe
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            counter_overflow_flag <= 1'b0;
        end else if (wrap16) begin
            counter_overflow_flag <= 1'b1; // RULE17
        end else if (counter_flag_clear) begin
            counter_overflow_flag <= 1'b0;
        end
    end

    // copy of the sticky cycle flag
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cycle_overflow_flag <= 1'b0;
        end else begin
            cycle_overflow_flag <= pwm.cycle_overflow_flag | cycle_wrap; // RULE13
        end
    end

    // interrupt request from either enabled flag
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            irq <= 1'b0;
        end else begin
            irq <= (counter_overflow_flag & mode.counter_overflow_irq_enable) // RULE7
                | (pwm.cycle_overflow_flag & pwm.cycle_overflow_irq_enable); // RULE11
        end
    end

    // per channel: wrap point, reload storage and its effect
    generate
        for (genvar n = 0; n < NCH; n++) begin : g_chan
            localparam logic [7:0] LOW_ADDR = CAM_CMP_LOW_BASE + 8'(n);
            localparam logic [7:0] HIGH_ADDR = CAM_CMP_HIGH_BASE + 8'(n);

            // sixteen-bit channels use the full counter wrap
            always_ff @(posedge clock or negedge rst_sync_n) begin
                if (!rst_sync_n) begin
                    channel_cycle_wrap[n] <= 1'b0;
                end else begin
                    channel_cycle_wrap[n] <= pwm16_mode[n] ? wrap16 : cycle_wrap; // RULE15
                end
            end

            // compare addresses reach reload bank only when selected
            always_ff @(posedge clock or negedge rst_sync_n) begin
                if (!rst_sync_n) begin
                    reload_mem[n] <= 16'h0000;
                end else if (sfr_req.wr && pwm.reload_bank_select) begin
                    if (sfr_req.addr == LOW_ADDR) begin
                        reload_mem[n][7:0] <= sfr_req.wdata; // RULE9
                    end else if (sfr_req.addr == HIGH_ADDR) begin
                        reload_mem[n][15:8] <= sfr_req.wdata; // RULE9
                    end
                end
            end

            // reload is offered only for 9 to 11 bit cycles
            always_ff @(posedge clock or negedge rst_sync_n) begin
                if (!rst_sync_n) begin
                    reload_value[16*n +: 16] <= 16'h0000;
                end else if (!pwm16_mode[n] && pwm.cycle_length_select != 2'h0) begin
                    reload_value[16*n +: 16] <= reload_mem[n]; // RULE10
                end else begin
                    reload_value[16*n +: 16] <= 16'h0000; // RULE10
                end
            end
        end
    endgenerate

    // read mux: data answers one cycle after the read strobe
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sfr_rdata <= CAM_RDATA_RESET;
            sfr_rdata_hit <= 1'b0;
        end else begin
            sfr_rdata <= CAM_RDATA_RESET;
            sfr_rdata_hit <= 1'b0;
            if (sfr_req.rd) begin
                if (sfr_req.addr == CAM_MODE_ADDR) begin
                    // bit 4 reads zero
                    sfr_rdata <= {mode.idle_suspend_select, mode.watchdog_enable_bit,
                        mode.watchdog_lock_bit, 1'b0, mode.timebase_select,
                        mode.counter_overflow_irq_enable};
                    sfr_rdata_hit <= 1'b1;
                end else if (sfr_req.addr == CAM_PWM_ADDR) begin
                    sfr_rdata <= {pwm.reload_bank_select, pwm.cycle_overflow_irq_enable,
                        pwm.cycle_overflow_flag, 3'h0, pwm.cycle_length_select}; // RULE16
                    sfr_rdata_hit <= 1'b1;
                end else if (pwm.reload_bank_select) begin
                    // with the bank clear the compare logic answers instead
                    for (int i = 0; i < NCH; i++) begin
                        if (sfr_req.addr == CAM_CMP_LOW_BASE + 8'(i)) begin
                            sfr_rdata <= reload_mem[i][7:0]; // RULE9
                            sfr_rdata_hit <= 1'b1;
                        end else if (sfr_req.addr == CAM_CMP_HIGH_BASE + 8'(i)) begin
                            sfr_rdata <= reload_mem[i][15:8]; // RULE9
                            sfr_rdata_hit <= 1'b1;
                        end
                    end
                end
            end
        end
    end
endmodule : cam_mode_pwm
`default_nettype wire

// *** sim/cam_mode_pwm_properties.sv ***
// port-level checks for the counter array mode and pwm block
`timescale 1ns/10ps
`default_nettype none
module cam_mode_pwm_properties #(
    parameter int NCH = 5
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register bus
    input wire cam_pkg::cam_sfr_req_type sfr_req,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_rdata_hit,
    // counter, flags and status
    input wire logic [15:0] main_counter,
    input wire logic timebase_tick,
    input wire logic counter_overflow_flag,
    input wire logic cycle_overflow_flag,
    input wire logic irq,
    input wire logic watchdog_active
);
    import cam_pkg::*;
    logic mode_wr; // write to the mode register
    logic pwm_wr; // write to the pwm register
    logic stray_rd; // read of an address nobody here owns
    assign mode_wr = sfr_req.wr && sfr_req.addr == CAM_MODE_ADDR;
    assign pwm_wr = sfr_req.wr && sfr_req.addr == CAM_PWM_ADDR;
    // compare addresses may answer in reload bank, so they never count as stray
    assign stray_rd = sfr_req.rd && sfr_req.addr != CAM_MODE_ADDR && sfr_req.addr != CAM_PWM_ADDR
        && !(sfr_req.addr >= CAM_CMP_LOW_BASE && sfr_req.addr < CAM_CMP_LOW_BASE + 8'(NCH))
        && sfr_req.addr < CAM_CMP_HIGH_BASE;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    chk_tick_steps: assert property (timebase_tick |-> main_counter == $past(main_counter) + 16'h0001)
        else $error("counter step wrong on tick");
    chk_hold_idle: assert property (!timebase_tick |-> $stable(main_counter))
        else $error("counter moved without tick");
    chk_wrap_flag: assert property (main_counter == 16'h0000 && $past(main_counter) == 16'hFFFF
        |-> counter_overflow_flag)
        else $error("wrap did not set overflow flag");
    chk_cycle_overflow_flag_sticky: assert property ($past(cycle_overflow_flag) && !$past(pwm_wr) && !$past(pwm_wr, 2)
        |-> cycle_overflow_flag)
        else $error("cycle flag dropped without a write");
    // irq may trail a flag by one cycle either way
    chk_irq_cause: assert property (irq |-> counter_overflow_flag || cycle_overflow_flag
        || $past(counter_overflow_flag) || $past(cycle_overflow_flag))
        else $error("irq with no flag behind it");
    chk_read_quiet: assert property (!$past(sfr_req.rd) |-> sfr_rdata == 8'h00 && !sfr_rdata_hit)
        else $error("read reply without a read");
    chk_stray_miss: assert property (stray_rd |=> !sfr_rdata_hit && sfr_rdata == 8'h00)
        else $error("unmapped read answered");
    chk_wdog_reset: assert property ($past(rst_n) == 1'b0 |-> watchdog_active)
        else $error("watchdog off after reset");
    chk_wdog_drop: assert property ($fell(watchdog_active) |-> $past(mode_wr, 2)
        && !$past(sfr_req.wdata[CAM_WATCHDOG_ENABLE_BIT_BIT], 2))
        else $error("watchdog dropped without clearing write");
    cov_wrap: cover property (main_counter == 16'h0000 && $past(main_counter) == 16'hFFFF);
    cov_cycle_flag: cover property ($rose(cycle_overflow_flag));
    cov_wdog_off: cover property ($fell(watchdog_active));
endmodule : cam_mode_pwm_properties
bind cam_mode_pwm cam_mode_pwm_properties #(.NCH(NCH)) u_cam_props (
    .clock, .rst_n, .sfr_req, .sfr_rdata, .sfr_rdata_hit, .main_counter, .timebase_tick,
    .counter_overflow_flag, .cycle_overflow_flag, .irq, .watchdog_active
);
`default_nettype wire

// *** sim/tb_counter_array_mode_pwm_config.sv ***
// self-checking bench for the counter array mode and pwm block
`timescale 1ns/10ps
`default_nettype none
module tb_counter_array_mode_pwm_config;
    import cam_pkg::*;
    // design inputs, all idle at time zero
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    cam_sfr_req_type sfr_req = '0;
    logic cpu_idle = 1'b0;
    logic run_enable = 1'b0;
    logic timer0_overflow = 1'b0;
    logic counter_flag_clear = 1'b0;
    logic [4:0] pwm16_mode = 5'h00;
    logic external_count_input = 1'b1;
    logic external_clock = 1'b0;
    // design outputs
    logic [7:0] sfr_rdata;
    logic sfr_rdata_hit;
    logic [15:0] main_counter;
    logic timebase_tick;
    logic counter_overflow_flag;
    logic cycle_overflow_flag;
    logic irq;
    logic watchdog_active;
    logic [4:0] channel_cycle_wrap;
    logic [79:0] reload_value;
    // bookkeeping
    int bad_count = 0;
    int total_checks = 0;
    logic [8:0] read_notes[$]; // expected {hit, data} per read
    logic [8:0] note;
    logic rd_seen = 1'b0;
    logic [15:0] start_count;
    logic [15:0] delta;
    logic [15:0] rv;
    int n;
    int cnt;
    int tick_table[11] = '{8, 24, 0, 5, 96, 2, 0, 0, 0, 96, 0}; // ticks per 96-cycle window

    always #10 clock = ~clock;

    cam_mode_pwm DUT (
        .clock, .rst_n, .sfr_req, .sfr_rdata, .sfr_rdata_hit, .cpu_idle, .run_enable, .timer0_overflow,
        .counter_flag_clear, .pwm16_mode, .external_count_input, .external_clock, .main_counter,
        .timebase_tick, .counter_overflow_flag, .cycle_overflow_flag, .irq, .watchdog_active,
        .channel_cycle_wrap, .reload_value
    );

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] expected);
        total_checks++;
        if (seen !== expected) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, expected, seen);
        end
    endtask : check

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    // wait whole cycles, then step past the edge so outputs are settled
    task automatic cycles(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask : cycles

    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        sfr_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        sfr_req <= '0;
        #1;
    endtask : bus_wr

    // the note is queued as the read is issued; the watcher compares it
    task automatic bus_rd(input logic [7:0] a, input logic hit, input logic [7:0] d);
        @(posedge clock);
        sfr_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        read_notes.push_back({hit, d});
        @(posedge clock);
        sfr_req <= '0;
        cycles(2);
    endtask : bus_rd

    // 96 cycles with every count pin busy; only the selected source may count
    task automatic window(input int t0_pulses);
        start_count = main_counter;
        for (int i = 0; i < 96; i++) begin
            @(posedge clock);
            timer0_overflow <= (i % 8 == 1) && (i / 8 < t0_pulses);
            external_count_input <= (i >= 40) || (i % 8 < 4);
            external_clock <= (i < 64) && (i % 4 < 2);
        end
        #1;
        delta = main_counter - start_count;
    endtask : window

    // reply watcher: one reply per read strobe, in issue order
    always @(posedge clock) rd_seen <= sfr_req.rd;
    always @(negedge clock) begin
        if (rd_seen === 1'b1) begin
            note = read_notes.pop_front();
            check("read", {7'h00, sfr_rdata_hit, sfr_rdata}, {7'h00, note});
        end
    end

    initial begin
        void'($urandom(32'hA61FF7BF));
        n = $urandom_range(10, 1);
        tick_table[2] = n;
        rv = 16'($urandom);
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        cycles(3);
        check("watchdog", watchdog_active, 16'h0001);
        bus_rd(CAM_MODE_ADDR, 1'b1, 8'h40);
        bus_rd(CAM_PWM_ADDR, 1'b1, 8'h00);
        bus_rd(8'h00, 1'b0, 8'h00);
        bus_wr(CAM_MODE_ADDR, 8'hFF);
        bus_rd(CAM_MODE_ADDR, 1'b1, 8'h40);
        bus_wr(CAM_MODE_ADDR, 8'h00);
        bus_rd(CAM_MODE_ADDR, 1'b1, 8'h00);
        check("watchdog", watchdog_active, 16'h0000);
        $display("test reset done");
        // every timebase code, then run off, idle with and without suspend
        for (int k = 0; k < 11; k++) begin
            @(posedge clock);
            run_enable <= (k != 8);
            cpu_idle <= (k > 8);
            bus_wr(CAM_MODE_ADDR, {k == 10, 3'b000, (k < 8) ? k[2:0] : 3'h4, 1'b0});
            cycles(16);
            window(n);
            check("ticks", delta, tick_table[k][15:0]);
        end
        $display("test timebase done");
        bus_wr(CAM_MODE_ADDR, 8'h09);
        cnt = 0;
        while (counter_overflow_flag !== 1'b1 && cnt < 70000) begin
            cycles(1);
            cnt++;
        end
        if (cnt >= 70000) begin
            bad_count++;
            complete_run();
        end
        cycles(2);
        check("irq", irq, 16'h0001);
        @(posedge clock);
        counter_flag_clear <= 1'b1;
        @(posedge clock);
        counter_flag_clear <= 1'b0;
        cycles(2);
        check("irq", irq, 16'h0000);
        $display("test overflow done");
        bus_wr(CAM_PWM_ADDR, 8'h40);
        cycles(300);
        check("irq", irq, 16'h0001);
        bus_rd(CAM_PWM_ADDR, 1'b1, 8'h60);
        check("cycle_overflow_flag", cycle_overflow_flag, 16'h0001);
        @(posedge clock);
        run_enable <= 1'b0;
        bus_wr(CAM_PWM_ADDR, 8'h20);
        bus_rd(CAM_PWM_ADDR, 1'b1, 8'h20);
        check("irq", irq, 16'h0000);
        bus_wr(CAM_PWM_ADDR, 8'h1C);
        bus_rd(CAM_PWM_ADDR, 1'b1, 8'h00);
        @(posedge clock);
        run_enable <= 1'b1;
        // every cycle length code, wraps counted over 2048 clocks
        for (int c = 0; c < 4; c++) begin
            bus_wr(CAM_PWM_ADDR, 8'(c));
            cycles(4);
            cnt = 0;
            repeat (2048) begin
                cycles(1);
                cnt += channel_cycle_wrap[1];
            end
            check("wraps", cnt[15:0], 16'(8 >> c));
        end
        $display("test cycle done");
        bus_wr(CAM_PWM_ADDR, 8'h81);
        bus_wr(CAM_CMP_LOW_BASE, rv[7:0]);
        bus_wr(CAM_CMP_HIGH_BASE, rv[15:8]);
        bus_rd(CAM_CMP_LOW_BASE, 1'b1, rv[7:0]);
        check("reload", reload_value[15:0], rv);
        @(posedge clock);
        pwm16_mode <= 5'h01;
        cycles(2);
        check("reload", reload_value[15:0], 16'h0000);
        // back to a cycle-length channel so only the length code blanks it
        @(posedge clock);
        pwm16_mode <= 5'h00;
        bus_wr(CAM_PWM_ADDR, 8'h00);
        bus_rd(CAM_CMP_HIGH_BASE, 1'b0, 8'h00);
        check("reload", reload_value[15:0], 16'h0000);
        $display("test reload done");
        bus_wr(CAM_MODE_ADDR, 8'h60);
        bus_wr(CAM_MODE_ADDR, 8'h00);
        bus_rd(CAM_MODE_ADDR, 1'b1, 8'h60);
        check("watchdog", watchdog_active, 16'h0001);
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        cycles(3);
        bus_rd(CAM_MODE_ADDR, 1'b1, 8'h40);
        bus_wr(CAM_MODE_ADDR, 8'h00);
        bus_rd(CAM_MODE_ADDR, 1'b1, 8'h00);
        // lock set with enable clear must survive a clearing write
        bus_wr(CAM_MODE_ADDR, 8'h20);
        bus_wr(CAM_MODE_ADDR, 8'h00);
        bus_rd(CAM_MODE_ADDR, 1'b1, 8'h20);
        check("watchdog", watchdog_active, 16'h0001);
        $display("test lock done");
        complete_run();
    end
endmodule : tb_counter_array_mode_pwm_config
`default_nettype wire
